// ==== src/fid_pkg.sv ====
package fid_pkg;
  localparam int HI_REG_LSB  = 8;
  localparam int LO_REG_LSB  = 4;
  localparam int OP_LSB      = 12;
  localparam logic [3:0]  ZERO_REG   = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] LONG_ALIGN = 32'hffff_fffc;
  localparam int LAT_CYCLES  = 1;

  typedef enum logic [3:0] {
    L_NONE, L_DST, L_SRC, L_TWO_REG, L_SRC_SHORT_DISP, L_DST_SHORT_DISP,
    L_TWO_REG_DISP, L_BYTE_DISP, L_LONG_BRANCH_DISP, L_REG_BYTE_DISP,
    L_IMMEDIATE, L_REG_IMMEDIATE
  } fid_layout_t;

  typedef enum logic [3:0] {
    M_NONE, M_DIRECT, M_INDIRECT, M_POSTINC, M_PREDEC, M_INDEXED, M_REG_DISP,
    M_GBR_DISP, M_GBR_INDEXED, M_PC_REL, M_IMM, M_CTRL_SYS
  } fid_mode_t;
endpackage

// ==== src/fid_decoder.sv ====
// Contract
// RULE1: Operand meaning follows the opcode bits.
// RULE2: Destination layout: bits 11-8 destination register.
// RULE3: Source layout: bits 11-8 source register.
// RULE4: Source layout writes a control register.
// RULE5: Two-register layout: 11-8 destination, 7-4 source.
// RULE6: Source short displacement: base 7-4, disp 3-0.
// RULE7: Destination short displacement: base 7-4, disp 3-0.
// RULE8: Two registers plus four-bit displacement.
// RULE9: Byte displacement layout uses bits 7-0.
// RULE10: Long branch displacement uses bits 11-0.
// RULE11: Register with byte PC-relative displacement.
// RULE12: Immediate layout uses bits 7-0.
// RULE13: Register with immediate: 11-8 and 7-0.
// RULE14: Long branch target is PC plus 2*sext.
// RULE15: Test and logic immediates are zero-extended.
// RULE16: Move, add, compare immediates are sign-extended.
// RULE17: Trap immediate zero-extended, times four.
// RULE18: No-operand layout yields no fields.
// RULE19: Fields presented with the accepted word.
`timescale 1ns/1ns
`default_nettype none
module fid_decoder (
  input  wire logic                clock_in,
  input  wire logic                nrst_in,
  input  wire logic                clk_en_in,
  input  wire logic                instr_valid_in,
  input  wire logic [15:0]         instr_in,
  input  wire logic [31:0]         pc_in,
  output logic                     valid_out,
  output fid_pkg::fid_layout_t     layout_out,
  output fid_pkg::fid_mode_t       src_mode_out,
  output fid_pkg::fid_mode_t       dst_mode_out,
  output logic [3:0]               src_reg_out,
  output logic [3:0]               dst_reg_out,
  output logic [31:0]              disp_out,
  output logic [31:0]              imm_out,
  output logic [31:0]              target_out
);
  import fid_pkg::*;
  function automatic logic [31:0] sx8(input logic [7:0] v);
    sx8 = {{24{v[7]}}, v};
  endfunction
  function automatic logic [31:0] zx8(input logic [7:0] v);
    zx8 = {24'h000000, v};
  endfunction
  logic        valid_r, valid_nxt;
  fid_layout_t layout_r, layout_nxt;
  fid_mode_t   smode_r, smode_nxt, dmode_r, dmode_nxt;
  logic [3:0]  sreg_r, sreg_nxt, dreg_r, dreg_nxt;
  logic [31:0] disp_r, disp_nxt, imm_r, imm_nxt, tgt_r, tgt_nxt;
  logic [3:0]  op, hi, mid, lo;
  assign op  = instr_in[OP_LSB +: 4];
  assign hi  = instr_in[HI_REG_LSB +: 4];
  assign mid = instr_in[LO_REG_LSB +: 4];
  assign lo  = instr_in[3:0];
  always_comb begin
    valid_nxt  = instr_valid_in;
    layout_nxt = L_NONE;
    smode_nxt  = M_NONE;
    dmode_nxt  = M_NONE;
    sreg_nxt   = ZERO_REG;
    dreg_nxt   = ZERO_REG;
    disp_nxt   = WORD_RESET;
    imm_nxt    = WORD_RESET;
    tgt_nxt    = pc_in;
    if (instr_valid_in) begin
      case (op) // see RULE1
        4'h0: begin
          if (lo == 4'h2 || lo == 4'h3 || lo == 4'ha || (lo == 4'h9 && mid == 4'h2)) begin
            layout_nxt = L_DST; // see RULE2
            dreg_nxt   = hi;
            dmode_nxt  = (lo == 4'h3) ? M_PC_REL : M_DIRECT;
            smode_nxt  = (lo == 4'h2 || lo == 4'ha) ? M_CTRL_SYS : M_NONE;
          end else if (lo[3:2] == 2'b01 || lo[3:2] == 2'b11) begin
            layout_nxt = L_TWO_REG; // see RULE5
            dreg_nxt   = hi;
            sreg_nxt   = mid;
            smode_nxt  = (lo[3:2] == 2'b11 && lo != 4'hf) ? M_INDEXED :
                         (lo == 4'hf) ? M_POSTINC : M_DIRECT;
            dmode_nxt  = (lo[3:2] == 2'b01 && lo != 4'h7) ? M_INDEXED :
                         (lo == 4'hf) ? M_POSTINC : M_DIRECT;
          end
        end
        4'h1, 4'h5: begin
          layout_nxt = L_TWO_REG_DISP; // see RULE8
          dreg_nxt   = hi;
          sreg_nxt   = mid;
          disp_nxt   = {26'h0, lo, 2'b00};
          smode_nxt  = op[2] ? M_REG_DISP : M_DIRECT;
          dmode_nxt  = op[2] ? M_DIRECT : M_REG_DISP;
        end
        4'h2, 4'h3, 4'h6: begin
          layout_nxt = L_TWO_REG; // see RULE5
          dreg_nxt   = hi;
          sreg_nxt   = mid;
          smode_nxt  = M_DIRECT;
          dmode_nxt  = M_DIRECT;
          if (op == 4'h2 && lo[3:2] == 2'b00) dmode_nxt = M_INDIRECT;
          if (op == 4'h2 && lo[3:2] == 2'b01) dmode_nxt = M_PREDEC;
          if (op == 4'h6 && lo[3:2] == 2'b00) smode_nxt = M_INDIRECT;
          if (op == 4'h6 && lo[3:2] == 2'b01) smode_nxt = M_POSTINC;
        end
        4'h4: begin
          if (lo == 4'hf) begin
            layout_nxt = L_TWO_REG;
            dreg_nxt   = hi;
            sreg_nxt   = mid;
            smode_nxt  = M_POSTINC;
            dmode_nxt  = M_POSTINC;
          end else if (lo == 4'h6 || lo == 4'h7 || lo == 4'ha || lo == 4'he) begin
            layout_nxt = L_SRC; // see RULE3
            sreg_nxt   = hi;
            smode_nxt  = lo[3] ? M_DIRECT : M_POSTINC; // see RULE4
            dmode_nxt  = M_CTRL_SYS;
          end else begin
            layout_nxt = L_DST; // see RULE2
            dreg_nxt   = hi;
            smode_nxt  = (lo == 4'h2 || lo == 4'h3) ? M_CTRL_SYS : M_NONE;
            dmode_nxt  = (lo == 4'h2 || lo == 4'h3) ? M_PREDEC :
                         (lo == 4'hb) ? M_INDIRECT : M_DIRECT;
          end
        end
        4'h7, 4'he: begin
          layout_nxt = L_REG_IMMEDIATE; // see RULE13
          dreg_nxt   = hi;
          smode_nxt  = M_IMM;
          dmode_nxt  = M_DIRECT;
          imm_nxt    = sx8(instr_in[7:0]); // see RULE16
        end
        4'h8: begin
          case (hi)
            4'h0, 4'h1: begin
              layout_nxt = L_DST_SHORT_DISP; // see RULE7
              dreg_nxt   = mid;
              dmode_nxt  = M_REG_DISP;
              smode_nxt  = M_DIRECT;
              disp_nxt   = {28'h0000000, lo} << hi[0];
            end
            4'h4, 4'h5: begin
              layout_nxt = L_SRC_SHORT_DISP; // see RULE6
              sreg_nxt   = mid;
              smode_nxt  = M_REG_DISP;
              dmode_nxt  = M_DIRECT;
              disp_nxt   = {28'h0000000, lo} << hi[0];
            end
            4'h8: begin
              layout_nxt = L_IMMEDIATE; // see RULE12
              smode_nxt  = M_IMM;
              dmode_nxt  = M_DIRECT;
              imm_nxt    = sx8(instr_in[7:0]); // see RULE16
            end
            4'h9, 4'hb, 4'hd, 4'hf: begin
              layout_nxt = L_BYTE_DISP; // see RULE9
              dmode_nxt  = M_PC_REL;
              disp_nxt   = sx8(instr_in[7:0]) << 1;
              tgt_nxt    = pc_in + (sx8(instr_in[7:0]) << 1);
            end
            default: layout_nxt = L_NONE;
          endcase
        end
        4'h9, 4'hd: begin
          layout_nxt = L_REG_BYTE_DISP; // see RULE11
          dreg_nxt   = hi;
          smode_nxt  = M_PC_REL;
          dmode_nxt  = M_DIRECT;
          disp_nxt   = zx8(instr_in[7:0]) << (op[2] ? 2 : 1);
          tgt_nxt    = (op[2] ? (pc_in & LONG_ALIGN) : pc_in) + disp_nxt;
        end
        4'ha, 4'hb: begin
          layout_nxt = L_LONG_BRANCH_DISP; // see RULE10
          dmode_nxt  = M_PC_REL;
          disp_nxt   = {{19{instr_in[11]}}, instr_in[11:0], 1'b0};
          tgt_nxt    = pc_in + disp_nxt; // see RULE14
        end
        4'hc: begin
          case (hi)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7: begin
              layout_nxt = L_BYTE_DISP; // see RULE9
              disp_nxt   = zx8(instr_in[7:0]) << ((hi == 4'h7) ? 2 : hi[1:0]);
              smode_nxt  = (hi == 4'h7) ? M_PC_REL : hi[2] ? M_GBR_DISP : M_DIRECT;
              dmode_nxt  = hi[2] ? M_DIRECT : M_GBR_DISP;
              tgt_nxt    = (pc_in & LONG_ALIGN) + disp_nxt;
            end
            4'h3: begin
              layout_nxt = L_IMMEDIATE; // see RULE12
              smode_nxt  = M_IMM;
              imm_nxt    = zx8(instr_in[7:0]) << 2; // see RULE17
            end
            default: begin
              layout_nxt = L_IMMEDIATE; // see RULE12
              smode_nxt  = M_IMM;
              dmode_nxt  = hi[2] ? M_GBR_INDEXED : M_DIRECT;
              imm_nxt    = zx8(instr_in[7:0]); // see RULE15
            end
          endcase
        end
        default: layout_nxt = L_NONE; // see RULE18
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      valid_r  <= 1'b0;
      layout_r <= L_NONE;
      smode_r  <= M_NONE;
      dmode_r  <= M_NONE;
      sreg_r   <= ZERO_REG;
      dreg_r   <= ZERO_REG;
      disp_r   <= WORD_RESET;
      imm_r    <= WORD_RESET;
      tgt_r    <= WORD_RESET;
    end else if (clk_en_in) begin
      valid_r  <= valid_nxt; // see RULE19
      layout_r <= layout_nxt;
      smode_r  <= smode_nxt;
      dmode_r  <= dmode_nxt;
      sreg_r   <= sreg_nxt;
      dreg_r   <= dreg_nxt;
      disp_r   <= disp_nxt;
      imm_r    <= imm_nxt;
      tgt_r    <= tgt_nxt;
    end
  end
  assign valid_out    = valid_r;
  assign layout_out   = layout_r;
  assign src_mode_out = smode_r;
  assign dst_mode_out = dmode_r;
  assign src_reg_out  = sreg_r;
  assign dst_reg_out  = dreg_r;
  assign disp_out     = disp_r;
  assign imm_out      = imm_r;
  assign target_out   = tgt_r;
  logic        acc_q;
  logic [15:0] w_q;
  logic [31:0] pc_q;
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      acc_q <= 1'b0;
      w_q   <= 16'h0000;
      pc_q  <= WORD_RESET;
    end else if (clk_en_in) begin
      acc_q <= instr_valid_in;
      w_q   <= instr_in;
      pc_q  <= pc_in;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_dst;
    acc_q && w_q[15:12] == 4'h0 && w_q[3:0] == 4'h2 |-> layout_out == L_DST && dst_reg_out == w_q[11:8];
  endproperty
  a_dst: assert property (p_dst) else $error("destination layout field wrong"); // see RULE2
  property p_src;
    acc_q && w_q[15:12] == 4'h4 && w_q[3:0] == 4'he |->
      layout_out == L_SRC && src_reg_out == w_q[11:8] && dst_mode_out == M_CTRL_SYS;
  endproperty
  a_src: assert property (p_src) else $error("source layout field wrong"); // see RULE4
  property p_two;
    acc_q && w_q[15:12] == 4'h3 |->
      layout_out == L_TWO_REG && dst_reg_out == w_q[11:8] && src_reg_out == w_q[7:4];
  endproperty
  a_two: assert property (p_two) else $error("two-register fields wrong"); // see RULE5
  property p_sdisp;
    acc_q && w_q[15:8] == 8'h84 |->
      layout_out == L_SRC_SHORT_DISP && src_reg_out == w_q[7:4] && disp_out == {28'h0, w_q[3:0]};
  endproperty
  a_sdisp: assert property (p_sdisp) else $error("short displacement wrong"); // see RULE6
  property p_rdisp;
    acc_q && w_q[15:12] == 4'h5 |-> disp_out == {26'h0, w_q[3:0], 2'b00};
  endproperty
  a_rdisp: assert property (p_rdisp) else $error("register displacement wrong"); // see RULE8
  property p_bra;
    acc_q && w_q[15:13] == 3'b101 |-> target_out == pc_q + {{19{w_q[11]}}, w_q[11:0], 1'b0};
  endproperty
  a_bra: assert property (p_bra) else $error("long branch target wrong"); // see RULE14
  property p_zx;
    acc_q && w_q[15:8] == 8'hc8 |-> imm_out == {24'h0, w_q[7:0]};
  endproperty
  a_zx: assert property (p_zx) else $error("logic immediate not zero-extended"); // see RULE15
  property p_sx;
    acc_q && w_q[15:12] == 4'he |-> imm_out == {{24{w_q[7]}}, w_q[7:0]};
  endproperty
  a_sx: assert property (p_sx) else $error("move immediate not sign-extended"); // see RULE16
  property p_trap;
    acc_q && w_q[15:8] == 8'hc3 |-> imm_out == {22'h0, w_q[7:0], 2'b00};
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector offset wrong"); // see RULE17
  property p_lat;
    clk_en_in && instr_valid_in |=> valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("accepted word not presented"); // see RULE19
  c_bra: cover property (valid_out && layout_out == L_LONG_BRANCH_DISP);
  c_trap: cover property (valid_out && w_q[15:8] == 8'hc3);
  c_two: cover property (valid_out && layout_out == L_TWO_REG ##1 valid_out);
endmodule
`default_nettype wire

// ==== tb/fid_fetch_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fid_fetch_model (
  input  wire logic        clock_in,
  output logic             valid_out,
  output logic [15:0]      word_out,
  output logic [31:0]      pc_out
);
  initial begin
    valid_out = 1'h0;
    word_out  = 16'h0000;
    pc_out    = 32'h0000_0000;
  end
  // Offers one word with its address, changed at the falling edge.
  task automatic offer(input logic [15:0] w, input logic [31:0] p);
    @(negedge clock_in);
    valid_out = 1'h1;
    word_out  = w;
    pc_out    = p;
  endtask
  // A released word shows the inverse of its last value.
  task automatic idle();
    @(negedge clock_in);
    valid_out = 1'h0;
    word_out  = ~word_out;
    pc_out    = ~pc_out;
  endtask
endmodule
`default_nettype wire

// ==== tb/fid_decoder_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module fid_decoder_tb_top;
  import fid_pkg::*;
  logic         clock_in;
  logic         nrst_in;
  logic         clk_en_in;
  logic         instr_valid_in;
  logic [15:0]  instr_in;
  logic [31:0]  pc_in;
  logic         valid_out;
  fid_layout_t  layout_out;
  fid_mode_t    src_mode_out;
  fid_mode_t    dst_mode_out;
  logic [3:0]   src_reg_out;
  logic [3:0]   dst_reg_out;
  logic [31:0]  disp_out;
  logic [31:0]  imm_out;
  logic [31:0]  target_out;
  int           err_total = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  fid_decoder DUT (
    .clock_in       (clock_in),
    .nrst_in        (nrst_in),
    .clk_en_in      (clk_en_in),
    .instr_valid_in (instr_valid_in),
    .instr_in       (instr_in),
    .pc_in          (pc_in),
    .valid_out      (valid_out),
    .layout_out     (layout_out),
    .src_mode_out   (src_mode_out),
    .dst_mode_out   (dst_mode_out),
    .src_reg_out    (src_reg_out),
    .dst_reg_out    (dst_reg_out),
    .disp_out       (disp_out),
    .imm_out        (imm_out),
    .target_out     (target_out)
  );
  fid_fetch_model FETCH (
    .clock_in  (clock_in),
    .valid_out (instr_valid_in),
    .word_out  (instr_in),
    .pc_out    (pc_in)
  );

  initial begin
    clock_in = 1'h0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [108:0] got, input logic [108:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic v, input fid_layout_t l, input logic [3:0] d, input logic [3:0] s,
                     input logic [31:0] dp, input logic [31:0] im, input logic [31:0] tg,
                     input logic use_t);
    cmp({valid_out, layout_out, dst_reg_out, src_reg_out, disp_out, imm_out,
         use_t ? target_out : 32'h0}, {v, l, d, s, dp, im, use_t ? tg : 32'h0});
  endtask
  task automatic chkm(input fid_mode_t sm, input fid_mode_t dm);
    cmp({101'h0, src_mode_out, dst_mode_out}, {101'h0, sm, dm});
  endtask
  task automatic dec(input logic [15:0] w, input logic [31:0] p);
    FETCH.offer(w, p);
    @(negedge clock_in);
  endtask

  task automatic t_branch();
    FETCH.offer(16'ha123, 32'h100);
    FETCH.offer(16'hafff, 32'h100);
    chk(1'h1, L_LONG_BRANCH_DISP, 4'h0, 4'h0, 32'h246, 32'h0, 32'h346, 1'h1);
    chkm(M_NONE, M_PC_REL);
    @(negedge clock_in);
    chk(1'h1, L_LONG_BRANCH_DISP, 4'h0, 4'h0, 32'hffff_fffe, 32'h0, 32'hfe, 1'h1);
  endtask
  task automatic t_regs();
    dec(16'h3a5c, 32'h0);
    chk(1'h1, L_TWO_REG, 4'ha, 4'h5, 32'h0, 32'h0, 32'h0, 1'h0);
    chkm(M_DIRECT, M_DIRECT);
    dec(16'h0729, 32'h0);
    chk(1'h1, L_DST, 4'h7, 4'h0, 32'h0, 32'h0, 32'h0, 1'h0);
    dec(16'h4b0e, 32'h0);
    chk(1'h1, L_SRC, 4'h0, 4'hb, 32'h0, 32'h0, 32'h0, 1'h0);
    chkm(M_DIRECT, M_CTRL_SYS);
    dec(16'h4b07, 32'h0);
    chkm(M_POSTINC, M_CTRL_SYS);
    dec(16'h0c02, 32'h0);
    chk(1'h1, L_DST, 4'hc, 4'h0, 32'h0, 32'h0, 32'h0, 1'h0);
    chkm(M_CTRL_SYS, M_DIRECT);
    dec(16'h0a5c, 32'h0);
    chk(1'h1, L_TWO_REG, 4'ha, 4'h5, 32'h0, 32'h0, 32'h0, 1'h0);
    chkm(M_INDEXED, M_DIRECT);
  endtask
  task automatic t_disp();
    dec(16'h8456, 32'h0);
    chk(1'h1, L_SRC_SHORT_DISP, 4'h0, 4'h5, 32'h6, 32'h0, 32'h0, 1'h0);
    dec(16'h8056, 32'h0);
    chk(1'h1, L_DST_SHORT_DISP, 4'h5, 4'h0, 32'h6, 32'h0, 32'h0, 1'h0);
    dec(16'h1a53, 32'h0);
    chk(1'h1, L_TWO_REG_DISP, 4'ha, 4'h5, 32'hc, 32'h0, 32'h0, 1'h0);
    chkm(M_DIRECT, M_REG_DISP);
    dec(16'h5a53, 32'h0);
    chk(1'h1, L_TWO_REG_DISP, 4'ha, 4'h5, 32'hc, 32'h0, 32'h0, 1'h0);
    chkm(M_REG_DISP, M_DIRECT);
    dec(16'h8bfe, 32'h200);
    chk(1'h1, L_BYTE_DISP, 4'h0, 4'h0, 32'hffff_fffc, 32'h0, 32'h1fc, 1'h1);
    chkm(M_NONE, M_PC_REL);
    dec(16'hc405, 32'h0);
    chk(1'h1, L_BYTE_DISP, 4'h0, 4'h0, 32'h5, 32'h0, 32'h0, 1'h0);
    chkm(M_GBR_DISP, M_DIRECT);
    dec(16'hd204, 32'h1002);
    chk(1'h1, L_REG_BYTE_DISP, 4'h2, 4'h0, 32'h10, 32'h0, 32'h1010, 1'h1);
    chkm(M_PC_REL, M_DIRECT);
  endtask
  task automatic t_imm();
    dec(16'hc880, 32'h0);
    chk(1'h1, L_IMMEDIATE, 4'h0, 4'h0, 32'h0, 32'h80, 32'h0, 1'h0);
    chkm(M_IMM, M_DIRECT);
    dec(16'h88ff, 32'h0);
    chk(1'h1, L_IMMEDIATE, 4'h0, 4'h0, 32'h0, 32'hffff_ffff, 32'h0, 1'h0);
    dec(16'hc3ff, 32'h0);
    chk(1'h1, L_IMMEDIATE, 4'h0, 4'h0, 32'h0, 32'h3fc, 32'h0, 1'h0);
    dec(16'h7380, 32'h0);
    chk(1'h1, L_REG_IMMEDIATE, 4'h3, 4'h0, 32'h0, 32'hffff_ff80, 32'h0, 1'h0);
    dec(16'he3ff, 32'h0);
    chk(1'h1, L_REG_IMMEDIATE, 4'h3, 4'h0, 32'h0, 32'hffff_ffff, 32'h0, 1'h0);
    dec(16'h0009, 32'h0);
    chk(1'h1, L_NONE, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 1'h0);
  endtask
  task automatic t_hold();
    dec(16'h3a5c, 32'h0);
    FETCH.offer(16'h7380, 32'h0);
    clk_en_in = 1'h0;
    repeat (2) @(negedge clock_in);
    chk(1'h1, L_TWO_REG, 4'ha, 4'h5, 32'h0, 32'h0, 32'h0, 1'h0);
    clk_en_in = 1'h1;
    FETCH.idle();
    chk(1'h1, L_REG_IMMEDIATE, 4'h3, 4'h0, 32'h0, 32'hffff_ff80, 32'h0, 1'h0);
    @(negedge clock_in);
    chk(1'h0, L_NONE, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 1'h0);
    dec(16'ha123, 32'h100);
    nrst_in = 1'h0;
    @(negedge clock_in);
    chk(1'h0, L_NONE, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 1'h1);
    nrst_in = 1'h1;
    @(negedge clock_in);
    chk(1'h1, L_LONG_BRANCH_DISP, 4'h0, 4'h0, 32'h246, 32'h0, 32'h346, 1'h1);
  endtask

  initial begin
    nrst_in   = 1'h0;
    clk_en_in = 1'h1;
    repeat (5) @(negedge clock_in);
    nrst_in = 1'h1;
    t_branch();
    t_regs();
    t_disp();
    t_imm();
    t_hold();
    stop_test();
  end
endmodule
`default_nettype wire
